/* sfcf_defines.vh */
// constants shared by the serial flash command front end
`ifndef SFCF_DEFINES_VH
`define SFCF_DEFINES_VH

// ===========================================
// opcodes
`define SFCF_OP_QUAD_ENTER   8'h38
`define SFCF_OP_QUAD_EXIT    8'hff
`define SFCF_OP_RESET_ARM    8'h66
`define SFCF_OP_RESET_GO     8'h99
`define SFCF_OP_WR_PERMIT    8'h06
`define SFCF_OP_VOL_PERMIT   8'h50
`define SFCF_OP_WR_FORBID    8'h04
`define SFCF_OP_STAT_READ    8'h05
`define SFCF_OP_STAT3_READ   8'h95
`define SFCF_OP_STAT_WRITE   8'h01
`define SFCF_OP_STAT3_WRITE  8'hc0
`define SFCF_OP_PAGE_PROG    8'h02
`define SFCF_OP_QPAGE_PROG   8'h32
`define SFCF_OP_WIPE_4K      8'h20
`define SFCF_OP_WIPE_HALF    8'h52
`define SFCF_OP_WIPE_64K     8'hd8
`define SFCF_OP_WIPE_CHIP_A  8'hc7
`define SFCF_OP_WIPE_CHIP_B  8'h60
`define SFCF_OP_SLEEP        8'hb9
`define SFCF_OP_WAKE_ID      8'hab
`define SFCF_OP_MAKER_DEV    8'h90
`define SFCF_OP_IDENT        8'h9f
`define SFCF_OP_OTP_ENTER    8'h3a
`define SFCF_OP_PARAM_READ   8'h5a
`define SFCF_OP_READ         8'h03
`define SFCF_OP_FAST_READ    8'h0b
`define SFCF_OP_BURST_READ   8'h0c
`define SFCF_OP_DUAL_OUT     8'h3b
`define SFCF_OP_QUAD_OUT     8'h6b
`define SFCF_OP_DUAL_IO      8'hbb
`define SFCF_OP_QUAD_IO      8'heb

// ===========================================
// identification bytes (values arbitrary)
`define SFCF_ID_MAKER        8'ha5
`define SFCF_ID_MEMTYPE      8'h3c
`define SFCF_ID_CAPACITY     8'h18
`define SFCF_ID_DEVICE       8'h17

// ===========================================
// lane widths and output enables
`define SFCF_W1              2'h0
`define SFCF_W2              2'h1
`define SFCF_W4              2'h2
`define SFCF_OE_SINGLE       4'h2
`define SFCF_OE_DUAL         4'h3
`define SFCF_OE_QUAD         4'hf

// ===========================================
// framing counts
`define SFCF_ADDR_BYTES      2'h3
`define SFCF_DUMMY_SPI       4'h8
`define SFCF_DUMMY_DUAL_IO   4'h4
`define SFCF_DUMMY_QUAD_BYTE 4'h2
`define SFCF_DUMMY_BASE      4'h6
`define SFCF_PROG_MIN_BYTES  3'h4
`define SFCF_WIPE_BYTES      3'h3
`define SFCF_WAKE_BYTES      3'h3
`define SFCF_ID_LAST_IDX     2'h2
`define SFCF_WIPE_KIND_4K    2'h0
`define SFCF_WIPE_KIND_HALF  2'h1
`define SFCF_WIPE_KIND_64K   2'h2
`define SFCF_WIPE_KIND_CHIP  2'h3

`endif

/* sfcf_front_end.v */
// command front end of a serial nor flash, sampled on ref_clk
// What this block does
// - msb first, sampled on sclk rise after select falls, opcode byte first
// - read-type data shifted out; output stops the moment select rises
// - write-type commands rejected unless bit count is a multiple of eight
// - page program ending mid byte programs nothing, write latch stays set
// - page program needs three address bytes plus at least one data byte
// - sector, half-block, block wipe need exactly three address bytes
// - array commands ignored while a write cycle is busy
// - 05h repeats status byte, 95h returns third status byte
// - 01h writes status, c0h writes third status, one data byte each
// - 06h permit, 50h volatile permit, 04h forbid; 50h directly before 01h
// - 02h serial data, 32h quad data high nibble first after address
// - 20h, 52h, d8h wipes with address; c7h or 60h chip wipe
// - b9h sleeps; abh plus three dummies wakes and repeats device id
// - 90h alternates maker/device by selector; 9fh returns three id bytes
// - 3ah enters otp; 5ah address plus dummy then streams parameter bytes
// - 03h no dummy; 0bh and 0ch eight dummy clocks in serial mode
// - dual/quad output eight dummies; dual io four, quad io six plus twice status3[5:4]
// - quad command mode refuses 03h 3bh bbh 6bh 32h; dummies from status3, 5ah two
// - after 38h every command uses four lanes until exit
// - ffh leaves quad command mode; no effect in serial mode
// - reset needs 66h then 99h in next frame; other commands disarm
// - soft reset clears status to zero and aborts program or wipe
// - program, wipe, c0h status write accepted only with write latch set; 01h also right after 50h
// - in deep sleep only the wake command is obeyed
// - soft reset does not wake from deep sleep
`include "sfcf_defines.vh"
`timescale 1ns/1ps
module sfcf_front_end (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        sclk,
  input  wire        cs_n,
  input  wire [3:0]  dqIn,
  output wire [3:0]  dqOut,
  output wire [3:0]  dqOe,
  input  wire        busyFlag,
  input  wire [7:0]  arrRdData,
  output reg  [23:0] arrAddr,
  output reg         paramSpace,
  output reg  [7:0]  progData,
  output reg         progStrobe,
  output reg         progGo,
  output reg         eraseGo,
  output reg  [1:0]  eraseKind,
  output reg         statusWrGo,
  output reg         status3WrGo,
  output reg  [7:0]  statusWrData,
  output reg         softReset,
  output reg         writeLatch,
  output reg  [5:0]  protBits,
  output reg  [7:0]  status3,
  output reg         deepSleep,
  output reg         quadCmdMode,
  output reg         otpMode
);
  // ===========================================
  // frame phases
  localparam [2:0] P_OPC   = 3'h0;
  localparam [2:0] P_ADDR  = 3'h1;
  localparam [2:0] P_DUMMY = 3'h2;
  localparam [2:0] P_DIN   = 3'h3;
  localparam [2:0] P_DOUT  = 3'h4;
  localparam [2:0] P_IGN   = 3'h5;

  // ===========================================
  // pin synchronisers and edges
  wire [5:0] pinSync;
  reg        sclkPrev;
  reg        csPrev;
  wire       sclkS = pinSync[5];
  wire       csS   = pinSync[4];
  wire [3:0] dqS   = pinSync[3:0];
  wire       csLow = ~csS;
  wire       rise  = sclkS & ~sclkPrev & csLow;
  wire       fall  = ~sclkS & sclkPrev & csLow;
  wire       csFall = ~csS & csPrev;
  wire       csRise = csS & ~csPrev;

  sfcf_sync #(.WIDTH(6), .RESET_VAL(6'h10)) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .din     ({sclk, cs_n, dqIn}),
    .dout    (pinSync)
  );

  // ===========================================
  // frame state
  reg [2:0] phase;
  reg [7:0] opc;
  reg       cmdOk;
  reg [7:0] inByte;
  reg [2:0] bitsInByte;
  reg [2:0] byteCnt;
  reg [1:0] inWidth;
  reg [1:0] outWidth;
  reg [1:0] dinWidth;
  reg [1:0] addrLeft;
  reg [3:0] dummyLeft;
  reg       toOut;
  reg [7:0] dataByte;
  reg [1:0] outIdx;
  reg       armed;
  reg       volEn;
  wire      byteTaken;

  wire [3:0] lanesN  = (inWidth == `SFCF_W4) ? 4'h4 : (inWidth == `SFCF_W2) ? 4'h2 : 4'h1;
  wire [7:0] newByte = (inWidth == `SFCF_W4) ? {inByte[3:0], dqS} :
                       (inWidth == `SFCF_W2) ? {inByte[5:0], dqS[1:0]} : {inByte[6:0], dqS[0]};
  wire [3:0] bitSum  = {1'b0, bitsInByte} + lanesN;
  wire       byteDone = bitSum[3];
  wire       aligned  = (bitsInByte == 3'h0);
  wire [3:0] sr3Dummy = `SFCF_DUMMY_BASE + {1'b0, status3[5:4], 1'b0};

  // ===========================================
  // opcode decode
  reg       isRead;
  reg       isArray;
  reg       known;
  reg       decOk;
  reg [2:0] decPhase;
  reg       decToOut;
  reg [3:0] decDummy;
  reg [1:0] decAddrW;
  reg [1:0] decOutW;
  reg [1:0] decDinW;
  always @* begin
    isRead  = (newByte == `SFCF_OP_READ) || (newByte == `SFCF_OP_FAST_READ) || (newByte == `SFCF_OP_BURST_READ) ||
              (newByte == `SFCF_OP_DUAL_OUT) || (newByte == `SFCF_OP_QUAD_OUT) ||
              (newByte == `SFCF_OP_DUAL_IO) || (newByte == `SFCF_OP_QUAD_IO);
    isArray = isRead || (newByte == `SFCF_OP_PAGE_PROG) || (newByte == `SFCF_OP_QPAGE_PROG) ||
              (newByte == `SFCF_OP_WIPE_4K) || (newByte == `SFCF_OP_WIPE_HALF) || (newByte == `SFCF_OP_WIPE_64K) ||
              (newByte == `SFCF_OP_WIPE_CHIP_A) || (newByte == `SFCF_OP_WIPE_CHIP_B);
    known   = isArray || (newByte == `SFCF_OP_QUAD_ENTER) || (newByte == `SFCF_OP_QUAD_EXIT) ||
              (newByte == `SFCF_OP_RESET_ARM) || (newByte == `SFCF_OP_RESET_GO) || (newByte == `SFCF_OP_WR_PERMIT) ||
              (newByte == `SFCF_OP_VOL_PERMIT) || (newByte == `SFCF_OP_WR_FORBID) || (newByte == `SFCF_OP_STAT_READ) ||
              (newByte == `SFCF_OP_STAT3_READ) || (newByte == `SFCF_OP_STAT_WRITE) ||
              (newByte == `SFCF_OP_STAT3_WRITE) || (newByte == `SFCF_OP_SLEEP) || (newByte == `SFCF_OP_WAKE_ID) ||
              (newByte == `SFCF_OP_MAKER_DEV) || (newByte == `SFCF_OP_IDENT) || (newByte == `SFCF_OP_OTP_ENTER) ||
              (newByte == `SFCF_OP_PARAM_READ);
    // unknown, busy, asleep, refused in quad mode
    decOk   = known && !(isArray && busyFlag) && !(deepSleep && newByte != `SFCF_OP_WAKE_ID) &&
              !(quadCmdMode && ((newByte == `SFCF_OP_READ) || (newByte == `SFCF_OP_DUAL_OUT) ||
                (newByte == `SFCF_OP_DUAL_IO) || (newByte == `SFCF_OP_QUAD_OUT) || (newByte == `SFCF_OP_QPAGE_PROG)));
    decToOut = isRead || (newByte == `SFCF_OP_PARAM_READ) || (newByte == `SFCF_OP_WAKE_ID) ||
               (newByte == `SFCF_OP_MAKER_DEV);
    if ((newByte == `SFCF_OP_STAT_READ) || (newByte == `SFCF_OP_STAT3_READ) || (newByte == `SFCF_OP_IDENT)) begin
      decPhase = P_DOUT;
    end else if (decToOut || (newByte == `SFCF_OP_PAGE_PROG) || (newByte == `SFCF_OP_QPAGE_PROG) ||
                 (newByte == `SFCF_OP_WIPE_4K) || (newByte == `SFCF_OP_WIPE_HALF) || (newByte == `SFCF_OP_WIPE_64K)) begin
      decPhase = P_ADDR;
    end else begin
      decPhase = P_DIN;
    end
    case (newByte)
      `SFCF_OP_FAST_READ, `SFCF_OP_BURST_READ: decDummy = quadCmdMode ? sr3Dummy : `SFCF_DUMMY_SPI;
      `SFCF_OP_DUAL_OUT, `SFCF_OP_QUAD_OUT:    decDummy = `SFCF_DUMMY_SPI;
      `SFCF_OP_DUAL_IO:                        decDummy = `SFCF_DUMMY_DUAL_IO;
      `SFCF_OP_QUAD_IO:                        decDummy = sr3Dummy;
      `SFCF_OP_PARAM_READ:                     decDummy = quadCmdMode ? `SFCF_DUMMY_QUAD_BYTE : `SFCF_DUMMY_SPI;
      default:                                 decDummy = 4'h0;
    endcase
    // four lanes everywhere in quad command mode
    decAddrW = (quadCmdMode || newByte == `SFCF_OP_QUAD_IO) ? `SFCF_W4 :
               (newByte == `SFCF_OP_DUAL_IO) ? `SFCF_W2 : `SFCF_W1;
    decOutW  = (quadCmdMode || newByte == `SFCF_OP_QUAD_OUT || newByte == `SFCF_OP_QUAD_IO) ? `SFCF_W4 :
               (newByte == `SFCF_OP_DUAL_OUT || newByte == `SFCF_OP_DUAL_IO) ? `SFCF_W2 : `SFCF_W1;
    // quad page data on four lanes
    decDinW  = (quadCmdMode || newByte == `SFCF_OP_QPAGE_PROG) ? `SFCF_W4 : `SFCF_W1;
  end

  // ===========================================
  // output byte source
  reg [7:0] nextByte;
  always @* begin
    case (opc)
      `SFCF_OP_STAT_READ:  nextByte = {protBits, writeLatch, busyFlag};
      `SFCF_OP_STAT3_READ: nextByte = status3;
      `SFCF_OP_WAKE_ID:    nextByte = `SFCF_ID_DEVICE;
      // selector bit chooses which id leads
      `SFCF_OP_MAKER_DEV:  nextByte = (arrAddr[0] ^ outIdx[0]) ? `SFCF_ID_DEVICE : `SFCF_ID_MAKER;
      `SFCF_OP_IDENT:      nextByte = (outIdx == 2'h0) ? `SFCF_ID_MAKER :
                                      (outIdx == 2'h1) ? `SFCF_ID_MEMTYPE : `SFCF_ID_CAPACITY;
      default:             nextByte = arrRdData;
    endcase
  end

  // shifter is dropped as soon as select rises
  sfcf_out_shift u_shift (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .active    (csLow && phase == P_DOUT),
    .fallEdge  (fall),
    .widthCode (outWidth),
    .nextByte  (nextByte),
    .dqOut     (dqOut),
    .dqOe      (dqOe),
    .byteTaken (byteTaken)
  );

  // ===========================================
  // sequencing and command execution
  always @(posedge ref_clk) begin
    progStrobe  <= 1'b0;
    progGo      <= 1'b0;
    eraseGo     <= 1'b0;
    statusWrGo  <= 1'b0;
    status3WrGo <= 1'b0;
    softReset   <= 1'b0;
    if (!rst_n) begin
      sclkPrev <= 1'b0;
      csPrev <= 1'b1;
      phase <= P_IGN;
      opc <= 8'h00;
      cmdOk <= 1'b0;
      inByte <= 8'h00;
      bitsInByte <= 3'h0;
      byteCnt <= 3'h0;
      inWidth <= `SFCF_W1;
      outWidth <= `SFCF_W1;
      dinWidth <= `SFCF_W1;
      addrLeft <= 2'h0;
      dummyLeft <= 4'h0;
      toOut <= 1'b0;
      dataByte <= 8'h00;
      outIdx <= 2'h0;
      armed <= 1'b0;
      volEn <= 1'b0;
      arrAddr <= 24'h000000;
      paramSpace <= 1'b0;
      progData <= 8'h00;
      eraseKind <= `SFCF_WIPE_KIND_4K;
      statusWrData <= 8'h00;
      writeLatch <= 1'b0;
      protBits <= 6'h00;
      status3 <= 8'h00;
      deepSleep <= 1'b0;
      quadCmdMode <= 1'b0;
      otpMode <= 1'b0;
    end else begin
      sclkPrev <= sclkS;
      csPrev <= csS;
      if (csFall) begin
        phase <= P_OPC;
        bitsInByte <= 3'h0;
        byteCnt <= 3'h0;
        outIdx <= 2'h0;
        cmdOk <= 1'b0;
        inWidth <= quadCmdMode ? `SFCF_W4 : `SFCF_W1;
      end else if (csRise) begin
        phase <= P_IGN;
        if (cmdOk) begin
          case (opc)
            `SFCF_OP_WR_PERMIT: if (aligned && byteCnt == 3'h0) writeLatch <= 1'b1;
            `SFCF_OP_VOL_PERMIT: if (aligned && byteCnt == 3'h0) volEn <= 1'b1;
            `SFCF_OP_WR_FORBID: begin
              if (aligned && byteCnt == 3'h0) begin
                writeLatch <= 1'b0;
                otpMode <= 1'b0;
              end
            end
            `SFCF_OP_STAT_WRITE: begin
              volEn <= 1'b0;
              if (aligned && byteCnt == 3'h1 && !busyFlag) begin
                if (volEn) begin
                  protBits <= dataByte[7:2];
                end else if (writeLatch) begin
                  protBits <= dataByte[7:2];
                  statusWrData <= dataByte;
                  statusWrGo <= 1'b1;
                  writeLatch <= 1'b0;
                end
              end
            end
            `SFCF_OP_STAT3_WRITE: begin
              if (aligned && byteCnt == 3'h1 && !busyFlag && writeLatch) begin
                status3 <= dataByte;
                statusWrData <= dataByte;
                status3WrGo <= 1'b1;
                writeLatch <= 1'b0;
              end
            end
            // program only on whole bytes with data
            `SFCF_OP_PAGE_PROG, `SFCF_OP_QPAGE_PROG: begin
              if (aligned && byteCnt >= `SFCF_PROG_MIN_BYTES && writeLatch) begin
                progGo <= 1'b1;
                writeLatch <= 1'b0;
              end
            end
            `SFCF_OP_WIPE_4K, `SFCF_OP_WIPE_HALF, `SFCF_OP_WIPE_64K: begin
              if (aligned && byteCnt == `SFCF_WIPE_BYTES && writeLatch) begin
                eraseGo <= 1'b1;
                writeLatch <= 1'b0;
                eraseKind <= (opc == `SFCF_OP_WIPE_4K) ? `SFCF_WIPE_KIND_4K :
                             (opc == `SFCF_OP_WIPE_HALF) ? `SFCF_WIPE_KIND_HALF : `SFCF_WIPE_KIND_64K;
              end
            end
            `SFCF_OP_WIPE_CHIP_A, `SFCF_OP_WIPE_CHIP_B: begin
              if (aligned && byteCnt == 3'h0 && writeLatch) begin
                eraseGo <= 1'b1;
                writeLatch <= 1'b0;
                eraseKind <= `SFCF_WIPE_KIND_CHIP;
              end
            end
            `SFCF_OP_SLEEP: if (aligned && byteCnt == 3'h0) deepSleep <= 1'b1;
            `SFCF_OP_WAKE_ID: if (byteCnt >= `SFCF_WAKE_BYTES) deepSleep <= 1'b0;
            // quad command mode entry and exit
            `SFCF_OP_QUAD_ENTER: if (aligned && byteCnt == 3'h0) quadCmdMode <= 1'b1;
            `SFCF_OP_QUAD_EXIT: if (aligned && byteCnt == 3'h0) quadCmdMode <= 1'b0;
            `SFCF_OP_OTP_ENTER: if (aligned && byteCnt == 3'h0) otpMode <= 1'b1;
            `SFCF_OP_RESET_ARM: if (aligned && byteCnt == 3'h0) armed <= 1'b1;
            `SFCF_OP_RESET_GO: begin
              armed <= 1'b0;
              if (armed && aligned && byteCnt == 3'h0) begin
                softReset <= 1'b1;
                protBits <= 6'h00;
                writeLatch <= 1'b0;
                volEn <= 1'b0;
                quadCmdMode <= 1'b0;
                otpMode <= 1'b0;
              end
            end
            default: ;
          endcase
        end
      end else if (rise && phase == P_DUMMY) begin
        dummyLeft <= dummyLeft - 4'h1;
        if (dummyLeft == 4'h1) phase <= P_DOUT;
      end else if (rise && (phase == P_OPC || phase == P_ADDR || phase == P_DIN)) begin
        inByte <= newByte;
        bitsInByte <= bitSum[2:0];
        if (byteDone && phase == P_OPC) begin
          opc <= newByte;
          cmdOk <= decOk;
          phase <= decOk ? decPhase : P_IGN;
          toOut <= decToOut;
          dummyLeft <= decDummy;
          inWidth <= (decPhase == P_DIN) ? decDinW : decAddrW;
          outWidth <= decOutW;
          dinWidth <= decDinW;
          addrLeft <= `SFCF_ADDR_BYTES;
          paramSpace <= (newByte == `SFCF_OP_PARAM_READ);
          if (newByte != `SFCF_OP_RESET_ARM && newByte != `SFCF_OP_RESET_GO) armed <= 1'b0;
          // volatile permit must directly precede status write
          if (newByte != `SFCF_OP_VOL_PERMIT && newByte != `SFCF_OP_STAT_WRITE) volEn <= 1'b0;
        end else if (byteDone) begin
          if (byteCnt != 3'h7) byteCnt <= byteCnt + 3'h1;
          if (phase == P_ADDR) begin
            arrAddr <= {arrAddr[15:0], newByte};
            addrLeft <= addrLeft - 2'h1;
            if (addrLeft == 2'h1) begin
              if (toOut) begin
                phase <= (dummyLeft == 4'h0) ? P_DOUT : P_DUMMY;
              end else begin
                phase <= P_DIN;
                inWidth <= dinWidth;
              end
            end
          end else begin
            dataByte <= newByte;
            // program data handed on per byte
            if (opc == `SFCF_OP_PAGE_PROG || opc == `SFCF_OP_QPAGE_PROG) begin
              progData <= newByte;
              progStrobe <= 1'b1;
            end
          end
        end
      end else if (byteTaken) begin
        // stream advances address per byte out
        // only the three-byte identity wraps early; the maker/device pair must keep alternating
        outIdx <= (opc == `SFCF_OP_IDENT && outIdx == `SFCF_ID_LAST_IDX) ? 2'h0 : outIdx + 2'h1;
        if (isReadOp(opc)) arrAddr <= arrAddr + 24'h000001;
      end
    end
  end

  function isReadOp;
    input [7:0] op;
    begin
      isReadOp = (op == `SFCF_OP_READ) || (op == `SFCF_OP_FAST_READ) || (op == `SFCF_OP_BURST_READ) ||
                 (op == `SFCF_OP_DUAL_OUT) || (op == `SFCF_OP_QUAD_OUT) || (op == `SFCF_OP_DUAL_IO) ||
                 (op == `SFCF_OP_QUAD_IO) || (op == `SFCF_OP_PARAM_READ);
    end
  endfunction
endmodule // sfcf_front_end

/* sfcf_front_end_chk.sv */
// assertions on the ports of the flash command front end
`timescale 1ns/1ps
module sfcf_front_end_chk (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       cs_n,
  input wire logic [3:0] dqOe,
  input wire logic       progGo,
  input wire logic       eraseGo,
  input wire logic       statusWrGo,
  input wire logic       softReset,
  input wire logic       writeLatch,
  input wire logic [5:0] protBits,
  input wire logic       deepSleep
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ====================
  // frame and lane checks
  AST_OE_IDLE: assert property (cs_n [*6] |-> dqOe == 4'h0) else $error("lines driven while deselected");
  AST_OE_CODE: assert property (dqOe inside {4'h0, 4'h2, 4'h3, 4'hf}) else $error("bad lane enable");
  // go pulses only once the select pin has been high a while
  AST_GO_END: assert property (progGo || eraseGo || statusWrGo || softReset |-> $past(cs_n, 2) && $past(cs_n))
    else $error("command run inside frame");
  AST_WIPE_PULSE: assert property (eraseGo |=> !eraseGo) else $error("wipe pulse too long");
  // ====================
  // write latch and power state
  AST_PROG_WL: assert property (progGo |-> $past(writeLatch)) else $error("program without latch");
  AST_WIPE_WL: assert property (eraseGo |-> $past(writeLatch)) else $error("wipe without latch");
  AST_WL_CLR: assert property (progGo || eraseGo |-> ##[1:2] !writeLatch) else $error("latch kept");
  AST_SLEEP_WR: assert property (deepSleep |-> !(progGo || eraseGo || statusWrGo)) else $error("write in sleep");
  AST_SLEEP_RST: assert property (deepSleep |-> !softReset) else $error("reset obeyed in sleep");
  AST_RST_CLR: assert property (softReset |-> ##[0:2] (protBits == 6'h00 && !writeLatch))
    else $error("status not cleared");
  CVR_PROG: cover property (progGo);
  CVR_WIPE: cover property (eraseGo);
  CVR_RST: cover property (softReset);
endmodule // sfcf_front_end_chk
bind sfcf_front_end sfcf_front_end_chk sfcf_front_end_chk_i (.ref_clk, .rst_n, .cs_n, .dqOe, .progGo, .eraseGo,
  .statusWrGo, .softReset, .writeLatch, .protBits, .deepSleep);

/* sfcf_host_model.sv */
// host serial controller model, mode 0, one or four lanes
`timescale 1ns/1ps
module sfcf_host_model (
  output logic       sclk,
  output logic       cs_n,
  output logic [3:0] dqIn,
  input  wire  [3:0] dqOut
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    dqIn = 4'h5;
  end
  // ====================
  // frame engine
  // msb first, opcode first
  task automatic frame(input logic [63:0] tx, input int nb, input int ln, input int rb, output logic [31:0] rx);
    rx = 32'h0;
    cs_n = 1'b0;
    for (int i = nb - 1; i >= 0; i -= ln) begin
      dqIn = (ln == 4) ? tx[i -: 4] : {~dqIn[3:1], tx[i]};
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    // sample late in the high phase: output lags the fall by a few clocks
    for (int j = 0; j < rb; j++) begin
      #80 sclk = 1'b1;
      #79 rx = {rx[30:0], dqOut[1]};
      #1 sclk = 1'b0;
    end
    #80 cs_n = 1'b1;
    // released lines must not keep the last bit
    dqIn = ~dqIn;
    #320;
  endtask
endmodule // sfcf_host_model

/* sfcf_out_shift.v */
// output shifter: one, two or four lanes, msb first
`include "sfcf_defines.vh"
`timescale 1ns/1ps
module sfcf_out_shift (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       active,
  input  wire       fallEdge,
  input  wire [1:0] widthCode,
  input  wire [7:0] nextByte,
  output reg  [3:0] dqOut,
  output reg  [3:0] dqOe,
  output reg        byteTaken
);
  reg  [7:0] sh;
  reg  [2:0] left;
  wire [3:0] lanesN   = (widthCode == `SFCF_W4) ? 4'h4 : (widthCode == `SFCF_W2) ? 4'h2 : 4'h1;
  wire [7:0] src      = (left == 3'h0) ? nextByte : sh;
  wire [3:0] leftNext = ((left == 3'h0) ? 4'h8 : {1'b0, left}) - lanesN;

  always @(posedge ref_clk) begin
    byteTaken <= 1'b0;
    if (!rst_n || !active) begin
      // chip select high releases the lines at once, even mid byte
      dqOe  <= 4'h0;
      dqOut <= 4'h0;
      sh    <= 8'h00;
      left  <= 3'h0;
    end else begin
      dqOe <= (widthCode == `SFCF_W4) ? `SFCF_OE_QUAD : (widthCode == `SFCF_W2) ? `SFCF_OE_DUAL : `SFCF_OE_SINGLE;
      if (fallEdge) begin
        case (widthCode)
          `SFCF_W4: begin
            dqOut <= src[7:4];
            sh    <= {src[3:0], 4'h0};
          end
          `SFCF_W2: begin
            dqOut <= {2'b00, src[7:6]};
            sh    <= {src[5:0], 2'b00};
          end
          default: begin
            dqOut <= {2'b00, src[7], 1'b0};
            sh    <= {src[6:0], 1'b0};
          end
        endcase
        left      <= leftNext[2:0];
        byteTaken <= (left == 3'h0);
      end
    end
  end
endmodule // sfcf_out_shift

/* sfcf_sync.v */
// two flip-flop synchroniser for pins from the host
`timescale 1ns/1ps
module sfcf_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input  wire             ref_clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);
  // first stage feeds the second only
  reg [WIDTH-1:0] meta;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      meta <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // sfcf_sync

/* tb_sfcf_front_end.sv */
// self-checking bench for the flash command front end
`include "sfcf_defines.vh"
`timescale 1ns/1ps
module tb_sfcf_front_end;
  typedef struct {logic [63:0] tx; int nb; int rb; logic [31:0] ex; logic wl;} sfcf_row_t;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        busyFlag = 1'b0;
  logic [31:0] rx;
  wire         sclk, cs_n, progGo, eraseGo, softReset, writeLatch, deepSleep, quadCmdMode;
  wire  [3:0]  dqIn, dqOut;
  wire  [7:0]  progData;
  wire  [1:0]  eraseKind;
  wire  [23:0] arrAddr;
  int          err_total = 0, tests_run = 0, nProg = 0, nWipe = 0, nRst = 0;
  sfcf_row_t   rows [9] = '{'{64'h06, 8, 0, 0, 1}, '{64'h05, 8, 16, 32'h0202, 1}, '{64'h04, 8, 0, 0, 0},
    '{64'h0c, 9, 0, 0, 0}, '{64'h9f, 8, 24, {`SFCF_ID_MAKER, `SFCF_ID_MEMTYPE, `SFCF_ID_CAPACITY}, 0},
    '{64'h90000001, 32, 32, {`SFCF_ID_DEVICE, `SFCF_ID_MAKER, `SFCF_ID_DEVICE, `SFCF_ID_MAKER}, 0},
    '{64'h90000000, 32, 16, {`SFCF_ID_MAKER, `SFCF_ID_DEVICE}, 0},
    '{64'h03000010, 32, 16, 32'h1011, 0}, '{64'h0b0000100a, 40, 8, 32'h10, 0}};
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    nProg += progGo;
    nWipe += eraseGo;
    nRst += softReset;
  end
  sfcf_host_model sfcf_host_model_i (.sclk, .cs_n, .dqIn, .dqOut);
  sfcf_front_end sfcf_front_end_i (.ref_clk, .rst_n, .sclk, .cs_n, .dqIn, .dqOut, .dqOe(), .busyFlag,
    .arrRdData(arrAddr[7:0]), .arrAddr, .paramSpace(), .progData, .progStrobe(), .progGo, .eraseGo, .eraseKind,
    .statusWrGo(), .status3WrGo(), .statusWrData(), .softReset, .writeLatch, .protBits(), .status3(),
    .deepSleep, .quadCmdMode, .otpMode());
  // ====================
  // checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tx(input logic [63:0] b, input int n, input int ln = 1);
    sfcf_host_model_i.frame(b, n, ln, 0, rx);
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    test_done;
  end
  // ====================
  // main sequence
  initial begin
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    foreach (rows[k]) begin
      sfcf_host_model_i.frame(rows[k].tx, rows[k].nb, 1, rows[k].rb, rx);
      chk(rx, rows[k].ex);
      chk(writeLatch, rows[k].wl);
    end
    tx(64'h06, 8);
    tx(64'h020000105a, 40);
    chk(nProg, 1);
    chk(progData, 8'h5a);
    chk(writeLatch, 0);
    tx(64'h06, 8);
    tx(64'h02000010, 32);
    chk(nProg, 1);
    tx(64'h0400002159, 41);
    chk(nProg, 1);
    chk(writeLatch, 1);
    tx(64'h2000000000, 40);
    chk(nWipe, 0);
    tx(64'hd8000000, 32);
    chk(nWipe, 1);
    chk(eraseKind, `SFCF_WIPE_KIND_64K);
    tx(64'h06, 8);
    busyFlag = 1'b1;
    tx(64'h20000000, 32);
    busyFlag = 1'b0;
    chk(nWipe, 1);
    tx(64'h66, 8);
    tx(64'h06, 8);
    tx(64'h99, 8);
    chk(nRst, 0);
    tx(64'h66, 8);
    tx(64'h99, 8);
    chk(nRst, 1);
    chk(writeLatch, 0);
    tx(64'hb9, 8);
    tx(64'h06, 8);
    chk(writeLatch, 0);
    tx(64'h66, 8);
    tx(64'h99, 8);
    chk(deepSleep, 1);
    sfcf_host_model_i.frame(64'hab000000, 32, 1, 8, rx);
    chk(rx, `SFCF_ID_DEVICE);
    tx(64'h38, 8);
    tx(64'h06, 8, 4);
    chk(writeLatch, 1);
    tx(64'hff, 8, 4);
    chk(quadCmdMode, 0);
    tx(64'hc030, 16);
    sfcf_host_model_i.frame(64'h95, 8, 1, 8, rx);
    chk(rx, 32'h30);
    tx(64'h50, 8);
    tx(64'h01fc, 16);
    sfcf_host_model_i.frame(64'h05, 8, 1, 8, rx);
    chk(rx, 32'hfc);
    tx(64'h06, 8);
    rst_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    sfcf_host_model_i.frame(64'h05, 8, 1, 8, rx);
    chk(rx, 32'h00);
    test_done;
  end
endmodule // tb_sfcf_front_end
